// ==== hdl/msui_led_gen.sv ====
// LED pattern generator: steady, off, slow blink or fast blink.
module msui_led_gen import msui_pkg::*; #(
   parameter longint unsigned SLOW_HALF = SLOW_HALF_CYC,
   parameter longint unsigned FAST_HALF = FAST_HALF_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Request and pin
   msui_led_if.gen req,
   output logic ledOn
);
   logic [CNT_W-1:0] phaseQ;
   logic blinkQ;
   msui_led_t lastQ;
   wire logic [CNT_W-1:0] halfLen = (req.mode == MSUI_LED_FAST) ? CNT_W'(FAST_HALF)
                                                                 : CNT_W'(SLOW_HALF);
   wire logic restart = req.mode != lastQ;
   wire logic phaseEnd = phaseQ >= halfLen - CNT_W'(1);
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         phaseQ <= '0;
         blinkQ <= 1'b1;
         lastQ <= MSUI_LED_ON;
         ledOn <= 1'b0;
      end else begin
         lastQ <= req.mode;
         phaseQ <= (restart || phaseEnd) ? '0 : phaseQ + CNT_W'(1);
         blinkQ <= restart ? 1'b1 : (phaseEnd ? ~blinkQ : blinkQ);
         unique case (req.mode)
            MSUI_LED_OFF: ledOn <= 1'b0;
            MSUI_LED_ON: ledOn <= 1'b1;
            MSUI_LED_SLOW, MSUI_LED_FAST: ledOn <= restart ? 1'b1 : blinkQ;
         endcase
      end
   end
endmodule

// ==== hdl/msui_top.sv ====
// Magnet reed switch and LED user interface of a battery sensor.
// How it works
// - Short tap restarts one-hour advertising, starts measurement
// - Short tap recognised gives one brief blink
// - Ten seconds continuous closure, then release, performs sensor reset
// - Fast blink warns before reset
// - Steady LED at reset point
// - Power-up lights LED for two seconds
// - Switch activation lights LED 200 ms
// - Slow blink while held under three seconds
// - Fast blink between three and ten seconds
// - Beyond ten seconds, LED steady; reset on release
// - Advertise one hour, then radio off
module msui_top import msui_pkg::*; #(
   parameter longint unsigned POWERUP = POWERUP_CYC,
   parameter longint unsigned ACK = ACK_CYC,
   parameter longint unsigned SLOW_END = SLOW_END_CYC,
   parameter longint unsigned RESET_AT = RESET_CYC,
   parameter longint unsigned ADV = ADV_CYC,
   parameter longint unsigned TAPBLINK = TAPBLINK_CYC,
   parameter longint unsigned DEBOUNCE = DEBOUNCE_CYC,
   parameter longint unsigned SLOW_HALF = SLOW_HALF_CYC,
   parameter longint unsigned FAST_HALF = FAST_HALF_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Reed switch, high while the magnet closes it
   input wire logic reedClosed,
   // Indicator LED, high lights it
   output logic ledOn,
   // System actions
   output logic advEnable,
   output logic measStart,
   output logic sensorReset
);
   typedef enum logic [2:0] {
      MSUI_POWERUP, MSUI_IDLE, MSUI_ACK, MSUI_SLOW, MSUI_FAST, MSUI_SOLID, MSUI_TAP
   } msui_state_t;

   msui_state_t stateQ, stateD;
   logic [2:0] syncQ;
   logic swQ;
   logic [CNT_W-1:0] dbCntQ, holdQ, ledCntQ, advCntQ;
   logic advQ, measQ, rstQ;
   msui_led_if ledReq();

   // True on the last cycle of a span that a counter measures from zero.
   function automatic logic spanDone(input logic [CNT_W-1:0] cnt, input longint unsigned len);
      return cnt >= CNT_W'(len) - CNT_W'(1);
   endfunction

   // Three-stage synchroniser; a change counts once stages two and three agree.
   always_ff @(posedge core_clk) begin
      if (sys_rst) syncQ <= '0;
      else syncQ <= {syncQ[1:0], reedClosed};
   end
   wire logic syncStable = syncQ[1] == syncQ[2];
   wire logic dbDiff = syncStable && (syncQ[2] != swQ);
   wire logic dbDone = spanDone(dbCntQ, DEBOUNCE);
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         dbCntQ <= '0;
         swQ <= 1'b0;
      end else begin
         dbCntQ <= (dbDiff && !dbDone) ? dbCntQ + CNT_W'(1) : '0;
         if (dbDiff && dbDone) swQ <= syncQ[2];
      end
   end

   // The hold timer runs from acknowledge entry; the LED timer restarts at each state entry.
   wire logic holdSlowEnd = spanDone(holdQ, SLOW_END);
   wire logic holdReset = spanDone(holdQ, RESET_AT);
   wire logic holdAck = spanDone(holdQ, ACK);
   wire logic ledPowerDone = spanDone(ledCntQ, POWERUP);
   wire logic tapDone = spanDone(ledCntQ, TAPBLINK);
   wire logic advDone = spanDone(advCntQ, ADV);
   wire logic tapEvent = (stateQ == MSUI_ACK || stateQ == MSUI_SLOW) && !swQ;

   // A release in the fast phase is ignored: too late for a tap, too early for a reset.
   always_comb begin
      stateD = stateQ;
      unique case (stateQ)
         MSUI_POWERUP: if (ledPowerDone) stateD = MSUI_IDLE;
         MSUI_IDLE: if (swQ) stateD = MSUI_ACK;
         MSUI_ACK: begin
            if (!swQ) stateD = MSUI_TAP;
            else if (holdAck) stateD = MSUI_SLOW;
         end
         MSUI_SLOW: begin
            if (!swQ) stateD = MSUI_TAP;
            else if (holdSlowEnd) stateD = MSUI_FAST;
         end
         MSUI_FAST: begin
            if (!swQ) stateD = MSUI_IDLE;
            else if (holdReset) stateD = MSUI_SOLID;
         end
         MSUI_SOLID: if (!swQ) stateD = MSUI_POWERUP;
         MSUI_TAP: if (tapDone) stateD = MSUI_IDLE;
         default: stateD = MSUI_IDLE;
      endcase
   end

   // A reset restarts the power-up sequence: steady light and, from the same cycle, a fresh advertising hour.
   wire logic enterPowerup = stateQ == MSUI_SOLID && stateD == MSUI_POWERUP;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         stateQ <= MSUI_POWERUP;
         holdQ <= '0;
         ledCntQ <= '0;
         advCntQ <= '0;
         advQ <= 1'b1;
         measQ <= 1'b0;
         rstQ <= 1'b0;
      end else begin
         stateQ <= stateD;
         holdQ <= (stateQ == MSUI_IDLE) ? '0 : holdQ + CNT_W'(1);
         ledCntQ <= (stateD != stateQ) ? '0 : ledCntQ + CNT_W'(1);
         if (tapEvent || enterPowerup) begin
            advCntQ <= '0;
            advQ <= 1'b1;
         end else if (advQ) begin
            advCntQ <= advDone ? advCntQ : advCntQ + CNT_W'(1);
            if (advDone) advQ <= 1'b0;
         end
         measQ <= tapEvent;
         rstQ <= enterPowerup;
      end
   end

   assign advEnable = advQ;
   assign measStart = measQ;
   assign sensorReset = rstQ;

   // LED request; steady at the reset point rather than off, so the operator sees it.
   wire logic ledSteady = stateQ == MSUI_POWERUP || stateQ == MSUI_ACK || stateQ == MSUI_SOLID ||
                          stateQ == MSUI_TAP;
   assign ledReq.mode = ledSteady ? MSUI_LED_ON :
                        (stateQ == MSUI_SLOW) ? MSUI_LED_SLOW :
                        (stateQ == MSUI_FAST) ? MSUI_LED_FAST : MSUI_LED_OFF;

   msui_led_gen #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)) ledGen (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .req(ledReq.gen),
      .ledOn(ledOn)
   );

   // The pin follows the requested pattern one register later, hence the two-cycle steps.
   sequence s_lit_later;
      ##2 ledOn;
   endsequence
   sequence s_dark_later;
      ##2 !ledOn;
   endsequence
   sequence s_long_hold;
      stateQ == MSUI_FAST ##1 stateQ == MSUI_SOLID;
   endsequence

   a_tap_meas: assert property (@(posedge core_clk) disable iff (sys_rst)
      tapEvent |=> measStart && advEnable) else $error("tap did not start measurement");
   a_tap_blink: assert property (@(posedge core_clk) disable iff (sys_rst)
      tapEvent |-> s_lit_later) else $error("tap blink missing");
   a_reset_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
      sensorReset |-> $past(stateQ) == MSUI_SOLID) else $error("reset without long hold");
   a_fast_warn: assert property (@(posedge core_clk) disable iff (sys_rst)
      stateQ == MSUI_FAST && swQ |-> holdQ <= CNT_W'(RESET_AT)) else $error("fast too long");
   a_solid_led: assert property (@(posedge core_clk) disable iff (sys_rst)
      stateQ == MSUI_SOLID [*2] |-> ledOn) else $error("led not solid at reset");
   a_power_led: assert property (@(posedge core_clk) disable iff (sys_rst)
      stateQ == MSUI_POWERUP [*2] |-> ledOn) else $error("led off at power up");
   a_ack_led: assert property (@(posedge core_clk) disable iff (sys_rst)
      stateQ == MSUI_ACK [*2] |-> ledOn) else $error("ack led off");
   a_slow_time: assert property (@(posedge core_clk) disable iff (sys_rst)
      stateQ == MSUI_SLOW |-> holdQ < CNT_W'(SLOW_END)) else $error("slow blink too long");
   a_fast_entry: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(stateQ == MSUI_FAST) |-> $past(holdSlowEnd)) else $error("fast blink early");
   a_reset_led: assert property (@(posedge core_clk) disable iff (sys_rst)
      sensorReset |-> s_lit_later) else $error("led not lit after reset");
   a_tap_release: assert property (@(posedge core_clk) disable iff (sys_rst)
      tapEvent |-> !holdSlowEnd || stateQ == MSUI_ACK) else $error("late release as tap");
   a_adv_off: assert property (@(posedge core_clk) disable iff (sys_rst)
      $fell(advEnable) |-> $past(advDone)) else $error("radio off early");

   // Pulses, phase boundaries and the switch path.
   a_meas_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
      measStart |=> !measStart) else $error("measurement request too long");
   a_meas_tap: assert property (@(posedge core_clk) disable iff (sys_rst)
      measStart |-> $past(tapEvent)) else $error("measurement without tap");
   a_adv_restart: assert property (@(posedge core_clk) disable iff (sys_rst)
      tapEvent |=> advCntQ == '0) else $error("advertising hour not restarted");
   a_tap_dark: assert property (@(posedge core_clk) disable iff (sys_rst)
      stateQ == MSUI_TAP && tapDone |-> s_dark_later) else $error("tap blink too long");
   a_led_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
      stateQ == MSUI_IDLE [*2] |-> !ledOn) else $error("led lit while idle");
   a_reset_once: assert property (@(posedge core_clk) disable iff (sys_rst)
      sensorReset |=> !sensorReset) else $error("reset request repeated");
   a_hold_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
      stateQ == MSUI_IDLE |=> holdQ == '0) else $error("hold timer not restarted");
   a_solid_entry: assert property (@(posedge core_clk) disable iff (sys_rst)
      s_long_hold |-> $past(holdReset)) else $error("solid light before reset point");
   a_solid_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      stateQ == MSUI_SOLID && swQ |=> stateQ == MSUI_SOLID) else $error("solid light left");
   a_power_exit: assert property (@(posedge core_clk) disable iff (sys_rst)
      $fell(stateQ == MSUI_POWERUP) |-> $past(ledPowerDone)) else $error("light cut short");
   a_power_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      stateQ == MSUI_POWERUP && !ledPowerDone |=> stateQ == MSUI_POWERUP)
      else $error("power-up ended early");
   a_ack_entry: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(stateQ == MSUI_ACK) |-> $past(swQ)) else $error("acknowledge without closure");
   a_ack_time: assert property (@(posedge core_clk) disable iff (sys_rst)
      stateQ == MSUI_ACK |-> holdQ < CNT_W'(ACK)) else $error("acknowledge light too long");
   a_slow_entry: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(stateQ == MSUI_SLOW) |-> $past(holdAck)) else $error("slow blink early");
   a_fast_release: assert property (@(posedge core_clk) disable iff (sys_rst)
      stateQ == MSUI_FAST && !swQ |=> stateQ == MSUI_IDLE && !measStart)
      else $error("release in fast phase acted");
   a_sw_settled: assert property (@(posedge core_clk) disable iff (sys_rst)
      $changed(swQ) |-> $past(syncStable) && $past(syncQ[2]) == swQ)
      else $error("switch changed while unsettled");
   a_sync_path: assert property (@(posedge core_clk) disable iff (sys_rst)
      syncQ[2] == $past(syncQ[1])) else $error("synchroniser stage skipped");
   a_adv_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      advEnable && !advDone |=> advEnable) else $error("radio off before the hour");
endmodule

// ==== shared/msui_led_if.sv ====
// Interface carrying the LED request from the control logic to the LED pattern generator.
interface msui_led_if;
   import msui_pkg::*;
   msui_led_t mode;
   modport ctrl (output mode);
   modport gen (input mode);
endinterface

// ==== shared/msui_pkg.sv ====
// Package with timing constants and LED pattern codes for the magnet switch user interface.
package msui_pkg;
   localparam int unsigned CLK_MHZ = 250;
   // Times in milliseconds as specified.
   localparam longint unsigned POWERUP_MS = 2000;
   localparam longint unsigned ACK_MS = 200;
   localparam longint unsigned SLOW_END_MS = 3000;
   localparam longint unsigned RESET_MS = 10000;
   localparam longint unsigned ADV_MS = 3600000;
   localparam longint unsigned SLOW_HALF_MS = 500;
   localparam longint unsigned FAST_HALF_MS = 100;
   localparam longint unsigned TAPBLINK_MS = 100;
   localparam longint unsigned DEBOUNCE_MS = 20;
   localparam longint unsigned CYC_PER_MS = 64'(CLK_MHZ) * 64'd1000;
   localparam longint unsigned POWERUP_CYC = POWERUP_MS * CYC_PER_MS;
   localparam longint unsigned ACK_CYC = ACK_MS * CYC_PER_MS;
   localparam longint unsigned SLOW_END_CYC = SLOW_END_MS * CYC_PER_MS;
   localparam longint unsigned RESET_CYC = RESET_MS * CYC_PER_MS;
   localparam longint unsigned ADV_CYC = ADV_MS * CYC_PER_MS;
   localparam longint unsigned SLOW_HALF_CYC = SLOW_HALF_MS * CYC_PER_MS;
   localparam longint unsigned FAST_HALF_CYC = FAST_HALF_MS * CYC_PER_MS;
   localparam longint unsigned TAPBLINK_CYC = TAPBLINK_MS * CYC_PER_MS;
   localparam longint unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
   localparam int CNT_W = 40;
   typedef enum logic [1:0] {MSUI_LED_OFF, MSUI_LED_ON, MSUI_LED_SLOW, MSUI_LED_FAST} msui_led_t;
endpackage

// ==== test/msui_magnet_model.sv ====
// Behavioural operator holding a magnet against the reed switch.
module msui_magnet_model (
   // Clock
   input wire logic core_clk,
   // Command from the bench
   input wire logic pressReq,
   input wire logic [31:0] holdLen,
   // Reed contact, low while open
   output logic reedClosed
);
   timeunit 1ns;
   timeprecision 1ps;
   initial reedClosed = 1'b0;
   // Contacts chatter on approach, so every closure starts with two short bounces.
   always @(posedge pressReq) begin
      repeat (2) begin
         @(negedge core_clk) reedClosed = 1'b1;
         @(negedge core_clk) reedClosed = 1'b0;
      end
      @(negedge core_clk) reedClosed = 1'b1;
      // The bench picks the hold so the magnet leaves in the acknowledge light, a blink phase or the solid light.
      repeat (holdLen) @(negedge core_clk);
      reedClosed = 1'b0;
   end
endmodule

// ==== test/testbench.sv ====
// Self-checking testbench for the magnet switch and LED user interface.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import msui_pkg::*;
   localparam longint unsigned PU = 20;
   localparam longint unsigned ACKC = 5, SLOWC = 40, RSTC = 100, TAPC = 4;
   localparam longint unsigned DBC = 3, SHALF = 3, FHALF = 1;
   localparam longint unsigned ADVC = 300;
   typedef struct {int hold; int meas; int rst;} msui_row_t;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic pressReq = 1'b0;
   int holdLen = 0;
   logic reedClosed, ledOn, advEnable, measStart, sensorReset;
   int err_total = 0;
   int n_checks = 0;
   int measCnt = 0;
   int rstCnt = 0;
   int m0, r0, tg;
   msui_row_t rows [4] = '{'{4, 1, 0}, '{15, 1, 0}, '{70, 0, 0}, '{110, 0, 1}};

   always #2 core_clk = ~core_clk;
   // Counted at the falling edge, where the registered pulses have settled.
   always @(negedge core_clk) begin
      if (measStart === 1'b1) measCnt++;
      if (sensorReset === 1'b1) rstCnt++;
   end

   msui_top #(.POWERUP(PU), .ACK(ACKC), .SLOW_END(SLOWC), .RESET_AT(RSTC), .ADV(ADVC),
      .TAPBLINK(TAPC), .DEBOUNCE(DBC), .SLOW_HALF(SHALF), .FAST_HALF(FHALF)) dut_u (
      .core_clk(core_clk), .sys_rst(sys_rst), .reedClosed(reedClosed), .ledOn(ledOn),
      .advEnable(advEnable), .measStart(measStart), .sensorReset(sensorReset));
   msui_magnet_model mag_u (.core_clk(core_clk), .pressReq(pressReq), .holdLen(holdLen),
      .reedClosed(reedClosed));

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic press(input int len);
      @(negedge core_clk);
      holdLen = len;
      pressReq = 1'b1;
      @(negedge core_clk);
      pressReq = 1'b0;
   endtask

   task automatic toggles(input int n, output int t);
      logic last;
      t = 0;
      last = ledOn;
      repeat (n) begin
         @(negedge core_clk);
         if (ledOn !== last) t++;
         last = ledOn;
      end
   endtask

   task automatic end_sim();
      if (err_total == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // The whole run needs about 960 cycles, so 5000 leaves ample margin.
   initial begin
      #(4 * 5000);
      err_total++;
      end_sim();
   end

   initial begin
      repeat (10) @(negedge core_clk);
      check("ledOn", ledOn, 0);
      check("advEnable", advEnable, 1);
      check("measStart", measStart, 0);
      check("sensorReset", sensorReset, 0);
      sys_rst = 1'b0;
      repeat (4) @(negedge core_clk);
      check("ledOn", ledOn, 1);
      repeat (PU - 6) @(negedge core_clk);
      check("ledOn", ledOn, 1);
      repeat (10) @(negedge core_clk);
      check("ledOn", ledOn, 0);
      repeat (ADVC) @(negedge core_clk);
      check("advEnable", advEnable, 0);
      foreach (rows[i]) begin
         m0 = measCnt;
         r0 = rstCnt;
         press(rows[i].hold);
         repeat (rows[i].hold + 60) @(negedge core_clk);
         check("measStart count", measCnt - m0, rows[i].meas);
         check("sensorReset count", rstCnt - r0, rows[i].rst);
         check("advEnable", advEnable, 1);
      end
      // Long hold watched phase by phase, then a tap while power-up still runs.
      m0 = measCnt;
      r0 = rstCnt;
      press(120);
      repeat (20) @(negedge core_clk);
      toggles(15, tg);
      check("slow toggles", tg >= 4 && tg <= 6, 1);
      repeat (25) @(negedge core_clk);
      toggles(15, tg);
      check("fast toggles", tg >= 13, 1);
      repeat (40) @(negedge core_clk);
      check("ledOn", ledOn, 1);
      toggles(8, tg);
      check("solid toggles", tg, 0);
      for (int k = 0; k < 40 && rstCnt == r0; k++) @(negedge core_clk);
      check("sensorReset count", rstCnt - r0, 1);
      press(4);
      check("ledOn", ledOn, 1);
      repeat (40) @(negedge core_clk);
      check("measStart count", measCnt - m0, 0);
      end_sim();
   end
endmodule
